// [core/uet_params.svh]
// Constants for the serial transmit block: register map, fields, codes.
// Assumes inclusion by bare name from every core file that needs it.
`ifndef UET_PARAMS_SVH
`define UET_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------
`define UET_ADDR_W 4
`define UET_OFF_MODE 4'h0
`define UET_OFF_STAT 4'h4
`define UET_OFF_TXD 4'h8
`define UET_OFF_BAUD 4'hC

// ----------------------------------------------------------------
// Mode register fields and reset
// ----------------------------------------------------------------
`define UET_MODE_ON 15
`define UET_MODE_FMT_HI 2
`define UET_MODE_FMT_LO 1
`define UET_MODE_STOP 0
`define UET_MODE_WMASK 16'h8007
`define UET_MODE_RST 16'h0000

// ----------------------------------------------------------------
// Status and control register fields and reset
// ----------------------------------------------------------------
`define UET_ST_TXISEL 15
`define UET_ST_TXBRK 11
`define UET_ST_TXEN 10
`define UET_ST_TXFULL 9
`define UET_ST_TXSHE 8
`define UET_ST_RXIDLE 4
`define UET_ST_WMASK 16'h8CE0
`define UET_ST_RST 16'h0000
`define UET_BAUD_RST 16'h0000

// ----------------------------------------------------------------
// Character format codes and buffer shape
// ----------------------------------------------------------------
`define UET_FMT_8EVEN 2'h1
`define UET_FMT_8ODD 2'h2
`define UET_FMT_9NONE 2'h3
`define UET_LAST_8 4'h7
`define UET_LAST_9 4'h8
`define UET_CHAR_W 9
`define UET_FIFO_DEPTH 4
`define UET_PTR_W 2
`define UET_CNT_W 3

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define UET_RESP_OKAY 2'h0
`define UET_RESP_SLVERR 2'h2

`endif

// [core/uet_pkg.sv]
// Types shared by the serial transmit block.
// Assumes the constants header is on the include path.
`include "uet_params.svh"

package uet_pkg;

  // One queued character, nine bits wide
  typedef logic [`UET_CHAR_W-1:0] uet_char_t;

  // Character format taken from the mode register
  typedef struct packed {
    logic [1:0] dataParitySelect;
    logic stopSelect;
  } uet_fmt_t;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_WAIT,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP1,
    TX_STOP2
  } uet_tx_state_t;

endpackage : uet_pkg

// [core/uet_tx_fifo.sv]
// Transmit holding buffer: four nine-bit entries in flip-flops.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps
`include "uet_params.svh"

module uet_tx_fifo (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  // Filling side
  input wire logic inValid,
  input wire uet_pkg::uet_char_t inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output uet_pkg::uet_char_t outData
);

  // Storage and pointers
  uet_pkg::uet_char_t mem [`UET_FIFO_DEPTH];
  logic [`UET_PTR_W-1:0] wrPtr;
  logic [`UET_PTR_W-1:0] rdPtr;
  logic [`UET_CNT_W-1:0] count;

  // Handshake decode
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;

  // Full refuses pushes without moving any entry
  assign inReady = (count != `UET_CNT_W'(`UET_FIFO_DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  // Pointer and count update
  always_ff @(posedge clk_sys) begin
    if (!rst_n || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + `UET_PTR_W'(1);
      end
      if (doPop) begin
        rdPtr <= rdPtr + `UET_PTR_W'(1);
      end
      count <= count + `UET_CNT_W'(doPush) - `UET_CNT_W'(doPop);
    end
  end

  // Entry write
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule : uet_tx_fifo

// [core/uet_uart.sv]
// Serial port enable, format selection and transmit path.
// Assumes an AXI4-Lite master on the register side and a port block
// that supplies latch and direction bits for the two shared pins.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "uet_params.svh"

// Notes on behaviour
// RQ1 - Enabled: out pin drives, in pin input
// RQ2 - Enabled and idle: out pin high
// RQ3 - Reset disables; disabled pins follow port
// RQ4 - Disable empties buffers, resets baud counter
// RQ5 - Disable clears flags, sets idle, empty
// RQ6 - Disable keeps other controls, mode, divisor
// RQ7 - Disable aborts; re-enable keeps configuration
// RQ8 - Format: 8 even, odd, none, 9
// RQ9 - One or two stop bits
// RQ10 - Reset format: 8 bits, none, 1 stop
// RQ11 - Software: format, divisor, enable, then data
// RQ12 - Free shifter loads at once, shifts next tick
// RQ13 - Late transmit enable starts stream immediately
// RQ14 - Transmit interrupt condition per select bit
// RQ15 - Nine-bit writes keep upper seven zero
// RQ16 - Holding buffer nine wide, four deep
// RQ17 - Full flag when buffer cannot accept
// RQ18 - Write to full buffer is dropped
// RQ19 - Buffer cleared by reset and by disable
// RQ20 - Start, data LSB first, parity, stops
module uet_uart (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [`UET_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`UET_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port latch and direction for the two pins, index 0 out, 1 in
  input wire logic [1:0] portLatch,
  input wire logic [1:0] portDirectionBits,
  // Serial pins
  output logic serialOutPinOut,
  output logic serialOutPinOe,
  output logic serialInPinOut,
  output logic serialInPinOe,
  // Transmit event
  output logic txIrq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awHeld;                         // Write address captured
  logic [`UET_ADDR_W-1:0] awAddr;       // Captured write address
  logic wHeld;                          // Write data captured
  logic [31:0] wData;                   // Captured write data
  logic [3:0] wStrb;                    // Captured byte enables
  logic [15:0] modeReg;                 // Mode register
  logic [15:0] ctrlReg;                 // Writable status bits
  logic [15:0] baudDivisorReg;          // Bit period divisor
  logic [15:0] next_ctrl;               // Control after write/disable
  logic [15:0] baudCnt;                 // Baud countdown
  uet_pkg::uet_tx_state_t txState;      // Sequencer state
  uet_pkg::uet_tx_state_t next_state;   // Sequencer next state
  uet_pkg::uet_char_t txShiftReg;       // Shift register
  uet_pkg::uet_char_t next_shift;       // Shift register next
  logic [3:0] bitIdx;                   // Data bit index
  logic [3:0] next_bitIdx;              // Data bit index next
  logic txLine;                         // Serial line level
  logic next_line;                      // Serial line next level
  logic parityBit;                      // Parity of loaded character
  logic fifoInReady;                    // Buffer accepts
  logic fifoOutValid;                   // Buffer holds a character
  uet_pkg::uet_char_t fifoOutData;      // Oldest character

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire moduleOn = modeReg[`UET_MODE_ON];
  wire uet_pkg::uet_fmt_t fmt = modeReg[`UET_MODE_FMT_HI:`UET_MODE_STOP];
  wire txEnable = ctrlReg[`UET_ST_TXEN];
  wire txBreak = ctrlReg[`UET_ST_TXBRK];
  wire txIrqSelect = ctrlReg[`UET_ST_TXISEL];
  wire txShiftEmpty = (txState == uet_pkg::TX_IDLE);
  // RQ17 full flag
  wire txFull = !fifoInReady;
  // RQ8 parity choice
  wire hasParity = (fmt.dataParitySelect == `UET_FMT_8EVEN) ||
                   (fmt.dataParitySelect == `UET_FMT_8ODD);
  wire [3:0] lastBit = (fmt.dataParitySelect == `UET_FMT_9NONE) ? `UET_LAST_9 : `UET_LAST_8;

  // ----------------------------------------------------------------
  // Bus handshake decode
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire regWrite = awHeld && wHeld && !s_axi_bvalid;
  wire hitModeW = (awAddr == `UET_OFF_MODE);
  wire hitStatW = (awAddr == `UET_OFF_STAT);
  wire hitTxdW = (awAddr == `UET_OFF_TXD);
  wire hitBaudW = (awAddr == `UET_OFF_BAUD);
  wire writeMapped = hitModeW || hitStatW || hitTxdW || hitBaudW;
  wire [15:0] laneMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};
  wire readTake = s_axi_arvalid && s_axi_arready;
  wire readMapped = (s_axi_araddr == `UET_OFF_MODE) || (s_axi_araddr == `UET_OFF_STAT) ||
                    (s_axi_araddr == `UET_OFF_TXD) || (s_axi_araddr == `UET_OFF_BAUD);

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  wire [15:0] wordIn = wData[15:0];
  wire [15:0] next_mode = (modeReg & ~(laneMask & `UET_MODE_WMASK)) |
                          (wordIn & laneMask & `UET_MODE_WMASK);
  wire [15:0] ctrlMerged = (ctrlReg & ~(laneMask & `UET_ST_WMASK)) |
                           (wordIn & laneMask & `UET_ST_WMASK);
  wire [15:0] next_baud = (baudDivisorReg & ~laneMask) | (wordIn & laneMask);
  wire [15:0] ctrlAfterWrite = (regWrite && hitStatW) ? ctrlMerged : ctrlReg;
  wire [15:0] disableMask = ~((16'h0001 << `UET_ST_TXEN) | (16'h0001 << `UET_ST_TXBRK));
  // RQ5 disable clears enable, break
  assign next_ctrl = moduleOn ? ctrlAfterWrite : (ctrlAfterWrite & disableMask);

  // Status view: receiver absent, so its flags read idle and clear
  wire [15:0] statusView = ctrlReg |
                           (16'(txFull) << `UET_ST_TXFULL) |
                           (16'(txShiftEmpty) << `UET_ST_TXSHE) |
                           (16'h0001 << `UET_ST_RXIDLE);
  wire [15:0] readWord = (s_axi_araddr == `UET_OFF_MODE) ? modeReg :
                         (s_axi_araddr == `UET_OFF_STAT) ? statusView :
                         (s_axi_araddr == `UET_OFF_BAUD) ? baudDivisorReg : 16'h0000;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are taken in either order, then joined
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (regWrite) begin
      awHeld <= 1'b0;
    end
  end

  // Data beat capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (regWrite) begin
      wHeld <= 1'b0;
    end
  end

  // Write response, held until taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UET_RESP_OKAY;
    end else if (regWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writeMapped ? `UET_RESP_OKAY : `UET_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer, one cycle after the address is taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UET_RESP_OKAY;
    end else if (readTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, readWord};
      s_axi_rresp <= readMapped ? `UET_RESP_OKAY : `UET_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // RQ3 reset leaves module off
  // RQ10 reset format 8N1
  // RQ6 disable keeps mode, divisor
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      modeReg <= `UET_MODE_RST;
      ctrlReg <= `UET_ST_RST;
      baudDivisorReg <= `UET_BAUD_RST;
    end else begin
      if (regWrite && hitModeW) begin
        modeReg <= next_mode;
      end
      ctrlReg <= next_ctrl;
      if (regWrite && hitBaudW) begin
        baudDivisorReg <= next_baud;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding buffer
  // ----------------------------------------------------------------
  // RQ18 full buffer drops write
  wire pushValid = regWrite && hitTxdW && wStrb[0] && moduleOn;
  // Shifter takes a character only when free and transmit is on
  wire popReady = txShiftEmpty && txEnable && moduleOn;
  wire loadShift = popReady && fifoOutValid;

  // RQ16 four entries of nine bits
  // RQ4 disable empties buffer
  // RQ19 reset empties buffer
  uet_tx_fifo txHoldingBuffer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(!moduleOn),
    .inValid(pushValid),
    .inData(wData[`UET_CHAR_W-1:0]),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outReady(popReady),
    .outData(fifoOutData)
  );

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Counter sits at zero while idle, so a fresh character ticks at once
  wire baudRun = moduleOn && txEnable && !txShiftEmpty;
  wire baudTick = baudRun && (baudCnt == 16'h0000);

  // RQ13 cleared count, immediate start
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !baudRun) begin
      baudCnt <= 16'h0000;
    end else if (baudCnt == 16'h0000) begin
      baudCnt <= baudDivisorReg;
    end else begin
      baudCnt <= baudCnt - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer, next state
  // ----------------------------------------------------------------
  // Each state after TX_IDLE moves on a baud tick; all but the stop states set the line for the next bit; TX_IDLE moves on a load
  always_comb begin
    next_state = txState;
    next_shift = txShiftReg;
    next_bitIdx = bitIdx;
    next_line = txLine;
    case (txState)
      uet_pkg::TX_IDLE: begin
        // RQ12 free shifter loads at once
        if (loadShift) begin
          next_state = uet_pkg::TX_WAIT;
          next_shift = fifoOutData;
        end
      end
      uet_pkg::TX_WAIT: begin
        // RQ20 low start bit
        if (baudTick) begin
          next_state = uet_pkg::TX_START;
          next_line = 1'b0;
        end
      end
      uet_pkg::TX_START: begin
        // First data bit, least significant first
        if (baudTick) begin
          next_state = uet_pkg::TX_DATA;
          next_line = txShiftReg[0];
          next_shift = txShiftReg >> 1;
          next_bitIdx = 4'h0;
        end
      end
      uet_pkg::TX_DATA: begin
        if (baudTick) begin
          if (bitIdx != lastBit) begin
            // More data bits
            next_line = txShiftReg[0];
            next_shift = txShiftReg >> 1;
            next_bitIdx = bitIdx + 4'h1;
          end else if (hasParity) begin
            // RQ8 optional parity bit
            next_state = uet_pkg::TX_PARITY;
            next_line = parityBit;
          end else begin
            // Straight to stop
            next_state = uet_pkg::TX_STOP1;
            next_line = 1'b1;
          end
        end
      end
      uet_pkg::TX_PARITY: begin
        if (baudTick) begin
          next_state = uet_pkg::TX_STOP1;
          next_line = 1'b1;
        end
      end
      uet_pkg::TX_STOP1: begin
        // RQ9 second stop bit
        if (baudTick) begin
          next_state = fmt.stopSelect ? uet_pkg::TX_STOP2 : uet_pkg::TX_IDLE;
        end
      end
      uet_pkg::TX_STOP2: begin
        if (baudTick) begin
          next_state = uet_pkg::TX_IDLE;
        end
      end
      default: begin
        next_state = uet_pkg::TX_IDLE;
        next_line = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Frame sequencer, registers
  // ----------------------------------------------------------------
  // RQ7 disable aborts the frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !moduleOn) begin
      txState <= uet_pkg::TX_IDLE;
      txShiftReg <= '0;
      bitIdx <= 4'h0;
      txLine <= 1'b1;
    end else begin
      txState <= next_state;
      txShiftReg <= next_shift;
      bitIdx <= next_bitIdx;
      txLine <= next_line;
    end
  end

  // Parity fixed at load: even is data XOR, odd its inverse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      parityBit <= 1'b0;
    end else if (loadShift) begin
      parityBit <= (fmt.dataParitySelect == `UET_FMT_8ODD) ? ~^fifoOutData[7:0] :
                   ^fifoOutData[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit interrupt
  // ----------------------------------------------------------------
  // Select clear: a character left the buffer; set: all sent
  wire frameDone = baudTick && (next_state == uet_pkg::TX_IDLE) && !txShiftEmpty;
  // RQ14 select picks event
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !moduleOn) begin
      txIrq <= 1'b0;
    end else begin
      txIrq <= txIrqSelect ? (frameDone && !fifoOutValid) : loadShift;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // RQ1 module owns both pins
  // RQ2 idle line high
  // RQ3 disabled pins follow port
  assign serialOutPinOut = moduleOn ? (txLine && !txBreak) : portLatch[0];
  assign serialOutPinOe = moduleOn ? 1'b1 : !portDirectionBits[0];
  assign serialInPinOut = portLatch[1];
  assign serialInPinOe = moduleOn ? 1'b0 : !portDirectionBits[1];

endmodule : uet_uart

// [test/uet_uart_props.sv]
// Checker for the serial transmit block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "uet_params.svh"

module uet_uart_props (
  // Clock and reset
  input logic clk_sys,
  input logic rst_n,
  // Register bus
  input logic [`UET_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Port bits and pins
  input logic [1:0] portLatch,
  input logic [1:0] portDirectionBits,
  input logic serialOutPinOut,
  input logic serialOutPinOe,
  input logic serialInPinOut,
  input logic serialInPinOe,
  input logic txIrq
);
  // ----
  // Shadow of the enable bit
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Write address and data taken together
  wire wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire wrMode = wrBoth && s_axi_awaddr == `UET_OFF_MODE && s_axi_wstrb[1];
  logic on;
  // Follows writes to the mode register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) on <= 1'b0;
    else if (wrMode) on <= s_axi_wdata[`UET_MODE_ON];
  end

  property p_on_pins; on && $past(on) |-> serialOutPinOe && !serialInPinOe; endproperty
  a_on_pins: assert property (p_on_pins) else $error("pins not taken over");
  property p_off_pins; !on && !$past(on) |-> serialOutPinOut == portLatch[0] &&
    serialOutPinOe == !portDirectionBits[0] && serialInPinOe == !portDirectionBits[1];
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("pins not following port");
  property p_in_latch; serialInPinOut == portLatch[1]; endproperty
  a_in_latch: assert property (p_in_latch) else $error("input pin latch lost");
  property p_b_next; wrBoth |-> ##2 s_axi_bvalid; endproperty
  a_b_next: assert property (p_b_next) else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rdata[31:16] == 0;
  endproperty
  a_r_next: assert property (p_r_next) else $error("read answer late or wide");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_ready; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read address ready wrong");
  property p_irq_pulse; txIrq |=> !txIrq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("transmit event too long");
endmodule : uet_uart_props

bind uet_uart uet_uart_props u_props (.*);

// [test/uet_rx_model.sv]
// Remote serial receiver that decodes frames on the line.
// Assumes a bit period of four clocks and a pulled-up line.
`timescale 1ns/10ps

module uet_rx_model (
  // Clock and line
  input logic clk_sys,
  input logic line,
  // Expected format
  input logic [1:0] fmt,
  input logic twoStop,
  // Results
  output logic [8:0] rxChar,
  output int nFrames,
  output int nBad
);
  localparam int P = 4;
  int i;
  // Frame decoder, sampling near mid-bit
  initial begin
    nFrames = 0;
    nBad = 0;
    rxChar = '0;
    forever begin
      @(posedge clk_sys iff line === 1'b0);
      repeat (P / 2 - 1) @(posedge clk_sys);
      rxChar = '0;
      if (line !== 1'b0) nBad++;
      for (i = 0; i < ((fmt == 2'h3) ? 9 : 8); i++) begin
        repeat (P) @(posedge clk_sys);
        rxChar[i] = line;
      end
      if (fmt == 2'h1 || fmt == 2'h2) begin
        repeat (P) @(posedge clk_sys);
        if (line !== (^rxChar[7:0] ^ (fmt == 2'h2))) nBad++;
      end
      repeat (P) @(posedge clk_sys);
      if (line !== 1'b1) nBad++;
      if (twoStop) begin
        repeat (P) @(posedge clk_sys);
        if (line !== 1'b1) nBad++;
      end
      nFrames++;
    end
  end
endmodule : uet_rx_model

// [test/uet_uart_tb.sv]
// Self-checking bench for the serial transmit block.
// Assumes the receiver model and the checker bind are compiled first.
`timescale 1ns/10ps
`include "uet_params.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module uet_uart_tb;
  // ----
  // Signals
  // ----
  typedef struct packed {logic [15:0] mode; logic [8:0] ch;} uet_row_t;
  uet_row_t rows [6] = '{'{16'h8000, 9'h0A5}, '{16'h8002, 9'h0C3}, '{16'h8004, 9'h081},
    '{16'h8006, 9'h1A5}, '{16'h8001, 9'h03C}, '{16'h8003, 9'h0F0}};
  logic clk_sys, rst_n, awv, wv, br, arv, rr, pinOut, pinOe, inOe, irq, mTwo;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, d;
  logic [1:0] mFmt;
  logic [8:0] rxChar;
  int n_errors = 0, n_tests = 0, nIrq = 0, nFrames, nBad, i, f, q, b;
  // Pulled-up line seen by the receiver
  wire line = pinOe ? pinOut : 1'b1;

  uet_uart dut (.clk_sys, .rst_n, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rr),
    .portLatch(2'b00), .portDirectionBits(2'b01), .serialOutPinOut(pinOut),
    .serialOutPinOe(pinOe), .serialInPinOut(), .serialInPinOe(inOe), .txIrq(irq));
  uet_rx_model rx (.clk_sys, .line, .fmt(mFmt), .twoStop(mTwo), .rxChar, .nFrames, .nBad);

  // Clock and event counter
  initial begin clk_sys = 0; forever #2.5 clk_sys = ~clk_sys; end
  always @(posedge clk_sys) if (irq === 1'b1) nIrq <= nIrq + 1;

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Bus write
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    int k;
    tb = 0;
    awa <= a; wd <= v; ws <= 4'hF; awv <= 1; wv <= 1;
    for (k = 0; k < 40 && !tb; k++) begin
      @(negedge clk_sys);
      ta = awv && dut.s_axi_awready; tw = wv && dut.s_axi_wready; tb = dut.s_axi_bvalid;
      @(posedge clk_sys);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    if (!tb) begin n_errors++; summarize(); end
  endtask : wr

  // Bus read
  task automatic rd(input logic [3:0] a);
    logic ta, tr;
    int k;
    tr = 0;
    ara <= a; arv <= 1;
    for (k = 0; k < 40 && !tr; k++) begin
      @(negedge clk_sys);
      ta = arv && dut.s_axi_arready; tr = dut.s_axi_rvalid; d = dut.s_axi_rdata;
      @(posedge clk_sys);
      if (ta) arv <= 0;
    end
    if (!tr) begin n_errors++; summarize(); end
  endtask : rd

  // Bounded wait for received frames
  task automatic waitFrames(input int n);
    int k;
    for (k = 0; k < 400 && nFrames < n; k++) @(posedge clk_sys);
    if (nFrames < n) begin n_errors++; summarize(); end
  endtask : waitFrames

  // ----
  // Main sequence
  // ----
  initial begin
    {awv, wv, arv, mTwo, awa, ara, ws} = 0; br = 1; rr = 1; wd = 0; mFmt = 0; rst_n = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(`UET_OFF_MODE); `CHK("mode", 32'h0, d)
    rd(`UET_OFF_STAT); `CHK("status", 32'h0110, d)
    `CHK("outOe", 1'b0, pinOe)
    `CHK("inOe", 1'b1, inOe)
    $display("reset test done");
    wr(`UET_OFF_BAUD, 32'h3);
    for (i = 0; i < 6; i++) begin
      mFmt = rows[i].mode[2:1]; mTwo = rows[i].mode[0]; f = nFrames; q = nIrq;
      wr(`UET_OFF_MODE, {17'h0, rows[i].mode[14:0]});
      wr(`UET_OFF_MODE, {16'h0, rows[i].mode});
      `CHK("idle", 1'b1, pinOut)
      `CHK("onOutOe", 1'b1, pinOe)
      `CHK("onInOe", 1'b0, inOe)
      wr(`UET_OFF_STAT, 32'h400);
      wr(`UET_OFF_TXD, {23'h0, rows[i].ch});
      waitFrames(f + 1);
      repeat (12) @(posedge clk_sys);
      `CHK("char", rows[i].ch, rxChar)
      `CHK("frame", 0, nBad)
      `CHK("irq", q + 1, nIrq)
    end
    $display("format test done");
    wr(`UET_OFF_STAT, 32'h0); q = nIrq; f = nFrames;
    for (i = 0; i < 5; i++) wr(`UET_OFF_TXD, 32'h11 + i);
    rd(`UET_OFF_STAT); `CHK("full", 1'b1, d[9])
    wr(`UET_OFF_STAT, 32'h8400);
    for (i = 0; i < 4; i++) begin
      waitFrames(f + i + 1); `CHK("queued", 9'h11 + i, rxChar)
    end
    repeat (150) @(posedge clk_sys);
    `CHK("dropped", f + 4, nFrames)
    `CHK("lastIrq", q + 1, nIrq)
    $display("buffer test done");
    wr(`UET_OFF_STAT, 32'h84E0); wr(`UET_OFF_TXD, 32'h55); wr(`UET_OFF_TXD, 32'h66);
    repeat (6) @(posedge clk_sys);
    wr(`UET_OFF_MODE, 32'h3);
    `CHK("offOe", 1'b0, pinOe)
    rd(`UET_OFF_STAT); `CHK("offStat", 32'h81F0, d)
    rd(`UET_OFF_MODE); `CHK("offMode", 32'h3, d)
    rd(`UET_OFF_BAUD); `CHK("baud", 32'h3, d)
    repeat (80) @(posedge clk_sys);
    f = nFrames; b = nBad;
    wr(`UET_OFF_MODE, 32'h8003); wr(`UET_OFF_STAT, 32'h84E0);
    repeat (150) @(posedge clk_sys);
    `CHK("flushed", f, nFrames)
    wr(`UET_OFF_TXD, 32'h5A); waitFrames(f + 1);
    `CHK("resume", 9'h05A, rxChar)
    `CHK("resumeFrame", b, nBad)
    $display("disable test done");
    summarize();
  end
endmodule : uet_uart_tb
